/* dv/dram_refresh_burst_control_tb.sv */
// self-checking bench for controller and dram ends joined by the link
`timescale 1ns/1ps
module dram_refresh_burst_control_tb
    import drbc_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic        req_bl8 = 1'b0;
    logic [2:0]  req_bank = 3'h0;
    logic [13:0] req_row = 14'h0000;
    logic [9:0]  req_col = 10'h000;
    logic [63:0] req_wdata = 64'h0;
    logic        pull_in_en = 1'b0;
    logic        sr_req = 1'b0;
    logic        req_ready, rd_valid, sr_grant, init_done;
    logic [63:0] rd_data;
    logic [4:0]  refresh_debt;
    logic        refresh_active, wr_fault, wr_fault_b;
    logic [13:0] refresh_row;
    logic [7:0]  banks_open, banks_b;
    logic [1:0]  burst_mode, mode_b;
    int          errors = 0;
    int          n_checks = 0;
    int          n_ref = 0;
    int          n_fault = 0;
    int          n_bad = 0;
    always #25 sys_clk = ~sys_clk;
    // ==========================================================
    // ends under test
    drbc_link_if link ();
    drbc_link_if link_b ();
    drbc_ctrl drbc_ctrl_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
        .req_valid(req_valid), .req_write(req_write), .req_bl8(req_bl8),
        .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
        .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .pull_in_en(pull_in_en), .sr_req(sr_req),
        .sr_grant(sr_grant), .refresh_debt(refresh_debt), .init_done(init_done));
    drbc_dram drbc_dram_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
        .refresh_active(refresh_active), .refresh_row(refresh_row),
        .banks_open(banks_open), .burst_mode(burst_mode), .wr_fault(wr_fault));
    // second dram faces a bench driver that breaks strobe timing
    drbc_dram drbc_dram_inst_b (.sys_clk(sys_clk), .rstn(rstn), .link(link_b),
        .refresh_active(), .refresh_row(),
        .banks_open(banks_b), .burst_mode(mode_b), .wr_fault(wr_fault_b));
    drbc_link_assertions drbc_link_assertions_inst (.sys_clk(sys_clk), .rstn(rstn),
        .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .addr(link.addr), .ctl_oe(link.ctl_oe), .ctl_dqs_o(link.ctl_dqs_o),
        .dev_oe(link.dev_oe));
    always @(posedge sys_clk)
    begin
        if (rstn && {link.cs_n, link.ras_n, link.cas_n, link.we_n} == CMD_REF)
            n_ref++;
        if (wr_fault_b === 1'b1)
            n_fault++;
        if (wr_fault === 1'b1)
            n_bad++;
    end
    // ==========================================================
    // shared tasks
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_req(input logic wr, input logic bl8, input logic [9:0] col,
                          input logic [63:0] wd);
        int i;
        for (i = 0; i < 400 && req_ready !== 1'b1; i++)
            @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_bl8   = bl8;
        req_bank  = 3'h2;
        req_row   = 14'h0001;
        req_col   = col;
        req_wdata = wd;
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (i = 0; i < 40 && !wr && rd_valid !== 1'b1; i++)
            @(negedge sys_clk);
    endtask
    task automatic cmd_b(input logic [3:0] c, input logic [13:0] a);
        @(negedge sys_clk);
        {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = c;
        link_b.addr = a;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_bursts();
        chk("otf mode", MODE_OTF, burst_mode);
        do_req(1'b1, 1'b1, 10'h000, 64'h7766554433221100);
        do_req(1'b0, 1'b1, 10'h000, 64'h0);
        chk("read eight", 64'h7766554433221100, rd_data);
        do_req(1'b0, 1'b0, 10'h006, 64'h0);
        chk("read chop", 64'h0000000055447766, rd_data);
        do_req(1'b1, 1'b0, 10'h001, 64'hDDCCBBAA);
        do_req(1'b0, 1'b1, 10'h005, 64'h0);
        chk("read wrap", 64'h44CCBBAADD776655, rd_data);
        chk("clean strobes", 0, n_bad);
    endtask
    task automatic t_refresh();
        int i;
        for (i = 0; i < 400 && refresh_active !== 1'b1; i++)
            @(negedge sys_clk);
        chk("refresh active", 1'b1, refresh_active);
        chk("refresh row", n_ref, refresh_row);
        repeat (4) @(negedge sys_clk);
        chk("refresh done", 1'b0, refresh_active);
        chk("banks idle", 8'h00, banks_open);
    endtask
    task automatic t_postpone();
        logic signed [4:0] top;
        logic              granted;
        top = 5'sh00;
        granted = 1'b0;
        sr_req = 1'b1;
        req_bl8 = 1'b1;
        req_write = 1'b0;
        req_valid = 1'b1;
        repeat (1500)
        begin
            @(negedge sys_clk);
            if ($signed(refresh_debt) > top)
                top = $signed(refresh_debt);
            // grants before the first owed refresh are legal
            granted = granted | (sr_grant === 1'b1 && top > 5'sh00);
        end
        req_valid = 1'b0;
        chk("debt peak", 5'h08, top);
        chk("grant with debt", 1'b0, granted);
        repeat (80) @(negedge sys_clk);
        chk("debt drained", 5'h00, refresh_debt);
        chk("grant when clear", 1'b1, sr_grant);
        sr_req = 1'b0;
    endtask
    task automatic t_pull_in();
        int nr;
        pull_in_en = 1'b1;
        repeat (300) @(negedge sys_clk);
        chk("debt floor", 5'h18, refresh_debt);
        pull_in_en = 1'b0;
        repeat (1000) @(negedge sys_clk);
        chk("credit held", 1'b1, refresh_debt[4]);
        nr = n_ref;
        repeat (500) @(negedge sys_clk);
        chk("refresh after credit", 1'b1, n_ref > nr);
    endtask
    task automatic t_fault();
        int k;
        chk("fixed mode", MODE_FIXED8, mode_b);
        cmd_b(CMD_ACT, 14'h0000);
        cmd_b(CMD_WR, 14'h0000);
        for (k = 0; k < 8; k++)
        begin
            cmd_b(CMD_NOP, 14'h0000);
            link_b.ctl_oe = 1'b1;
            link_b.ctl_dq_o = 8'hA0 + 8'(k);
            link_b.ctl_dqs_o = (k != 3);
        end
        cmd_b(CMD_NOP, 14'h0000);
        link_b.ctl_oe = 1'b0;
        cmd_b(CMD_PRE, ADDR_PRE_ALL);
        chk("fault pulses", 1, n_fault);
        cmd_b(CMD_ACT, 14'h0000);
        chk("banks after pre", 8'h00, banks_b);
        cmd_b(CMD_RD, 14'h0000);
        // first beat leaves the dram one cycle after decode
        cmd_b(CMD_NOP, 14'h0000);
        for (k = 0; k < 8; k++)
        begin
            cmd_b(CMD_NOP, 14'h0000);
            chk("read after fault", 8'hA0 + 8'(k), link_b.dq);
        end
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        int i;
        {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = CMD_DES;
        link_b.ba = 3'h0;
        link_b.addr = 14'h0000;
        link_b.ctl_oe = 1'b0;
        link_b.ctl_dqs_o = 1'b0;
        link_b.ctl_dq_o = 8'h00;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        for (i = 0; i < 50 && init_done !== 1'b1; i++)
            @(negedge sys_clk);
        t_fault();
        t_bursts();
        t_refresh();
        t_postpone();
        t_pull_in();
        finish_test();
    end
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        errors++;
        finish_test();
    end
endmodule

/* dv/drbc_link_assertions.sv */
// concurrent checks on the controller to dram link
`timescale 1ns/1ps
module drbc_link_assertions
    import drbc_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // command pins
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [13:0] addr,
    // data enables and write strobe
    input wire logic        ctl_oe,
    input wire logic        ctl_dqs_o,
    input wire logic        dev_oe
);
    // slack covers an access in flight when the debt tops out
    localparam int REF_GAP_MAX = 9 * REFI_CYCLES + 32;
    logic [3:0]  cmd;
    logic        row_open;
    logic [10:0] gap_cnt;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // helper state
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            row_open <= 1'b0;
            gap_cnt  <= 11'h000;
        end
        else
        begin
            if (cmd == CMD_ACT)
                row_open <= 1'b1;
            else if (cmd == CMD_PRE)
                row_open <= 1'b0;
            gap_cnt <= (cmd == CMD_REF) ? 11'h000 : gap_cnt + 11'h001;
        end
    end
    // ==========================================================
    // burst shapes
    sequence s_wr8;
        (ctl_oe && ctl_dqs_o) [*8] ##1 !ctl_oe;
    endsequence
    sequence s_wr4;
        (ctl_oe && ctl_dqs_o) [*4] ##1 !ctl_oe;
    endsequence
    // dram drives one cycle after it decodes the read
    sequence s_rd8;
        !dev_oe ##1 dev_oe [*8] ##1 !dev_oe;
    endsequence
    sequence s_rd4;
        !dev_oe ##1 dev_oe [*4] ##1 !dev_oe;
    endsequence
    // ==========================================================
    // properties
    chk_ref_nop_hold: assert property (cmd == CMD_REF |=> (cmd == CMD_NOP) [*3])
        else $error("non-nop command inside refresh cycle time");
    chk_ref_banks_idle: assert property (cmd == CMD_REF |-> !row_open && !ctl_oe)
        else $error("refresh issued with a row open");
    chk_wr_eight_len: assert property (cmd == CMD_WR && addr[ADDR_BL_BIT] |=> s_wr8)
        else $error("eight-beat write has wrong length");
    chk_wr_chop_len: assert property (cmd == CMD_WR && !addr[ADDR_BL_BIT] |=> s_wr4)
        else $error("chopped write has wrong length");
    chk_rd_eight_len: assert property (cmd == CMD_RD && addr[ADDR_BL_BIT] |=> s_rd8)
        else $error("eight-beat read has wrong length");
    chk_rd_chop_len: assert property (cmd == CMD_RD && !addr[ADDR_BL_BIT] |=> s_rd4)
        else $error("chopped read has wrong length");
    chk_strobe_each_beat: assert property (ctl_oe |-> ctl_dqs_o && !dev_oe)
        else $error("write beat without strobe");
    chk_ref_gap_max: assert property (gap_cnt <= REF_GAP_MAX)
        else $error("refresh gap too long");
endmodule

/* verilog/drbc_ctrl.sv */
// controller end: closed-page access sequencer with refresh debt scheduling
// Operation
// (RQ1) select bit picks chop four or eight
// (RQ2) select bit never part of column
// (RQ3) eight beats: fixed mode or select high
// (RQ4) refresh decoded from command pin pattern
// (RQ5) banks precharged and idle before refresh
// (RQ6) refresh row from internal counter
// (RQ7) refresh ends with banks precharged
// (RQ8) only nop after refresh for cycle time
// (RQ9) one refresh command per needed refresh
// (RQ10) at most eight refreshes deferred
// (RQ11) up to eight refreshes pulled in
// (RQ12) pull-ins beyond eight earn no credit
// (RQ13) deferred refreshes done before self-refresh
// (RQ14) setup or hold error corrupts location only
// (RQ15) strobe error corrupts location, no hang
// (RQ16) every strobe edge of burst meets timing
// (RQ17) signed clamped debt counter drives scheduling
`timescale 1ns/1ps
module drbc_ctrl
    import drbc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // link
    drbc_link_if.ctrl        link,
    // access request
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_bl8,
    input  wire logic [2:0]  req_bank,
    input  wire logic [13:0] req_row,
    input  wire logic [9:0]  req_col,
    input  wire logic [63:0] req_wdata,
    output logic             req_ready,
    // read return
    output logic             rd_valid,
    output logic [63:0]      rd_data,
    // refresh control
    input  wire logic        pull_in_en,
    input  wire logic        sr_req,
    output logic             sr_grant,
    output logic [4:0]       refresh_debt,
    output logic             init_done
);

    // ==========================================================
    // state
    typedef enum logic [2:0] {
        S_INIT,
        S_IDLE,
        S_ACT,
        S_DATA,
        S_PRE,
        S_WAIT
    } drbc_ctl_state_t;

    typedef struct packed {
        drbc_ctl_state_t   st;
        logic [3:0]        cmd;
        logic [2:0]        ba;
        logic [13:0]       addr;
        logic [7:0]        dq;
        logic              dqs;
        logic              oe;
        logic [7:0]        wait_cnt;
        logic [3:0]        beat;
        logic              wr;
        logic              bl8;
        logic [9:0]        col;
        logic [63:0]       wbuf;
        logic [63:0]       rbuf;
        logic              rd_valid;
        logic              req_ready;
        logic [7:0]        refi_cnt;
        logic signed [4:0] debt;
        logic              sr_grant;
        logic              init_done;
    } drbc_ctl_t;

    localparam drbc_ctl_t CTL_RST = '{st: S_INIT, cmd: CMD_DES, default: '0};

    drbc_ctl_t   s;
    drbc_ctl_t   n;
    logic        tick;
    logic        ref_issue;
    logic [63:0] rb;
    logic [3:0]  len;

    // ==========================================================
    // next state
    always_comb
    begin
        n          = s;
        n.cmd      = CMD_NOP;
        n.rd_valid = 1'b0;
        ref_issue  = 1'b0;
        len        = beats(s.bl8);
        rb         = {link.dq, s.rbuf[63:8]};
        // (RQ9) one owed refresh per average interval
        tick       = (s.refi_cnt == REFI_CYCLES - 8'h01);
        n.refi_cnt = tick ? 8'h00 : s.refi_cnt + 8'h01;
        unique case (s.st)
            S_INIT:
            begin
                n.cmd      = CMD_MRS;
                n.ba       = 3'h0;
                n.addr     = {12'h000, MODE_OTF};
                n.wait_cnt = MRD_CYCLES - 8'h01;
                n.st       = S_WAIT;
            end
            S_IDLE:
            begin
                if (req_valid && s.req_ready)
                begin
                    n.cmd  = CMD_ACT;
                    n.ba   = req_bank;
                    n.addr = req_row;
                    n.wr   = req_write;
                    n.bl8  = req_bl8;
                    n.col  = req_col;
                    n.wbuf = req_wdata;
                    n.st   = S_ACT;
                end
                // (RQ17) owed refreshes first, then optional pull-in
                else if (s.debt > 5'sh00 || (pull_in_en && s.debt > -DEBT_MAX))
                begin
                    // (RQ5) idle only after precharge-all, refresh or mode set and its wait
                    ref_issue  = 1'b1;
                    n.cmd      = CMD_REF;
                    n.wait_cnt = RFC_CYCLES - 8'h01;
                    n.st       = S_WAIT;
                end
            end
            S_ACT:
            begin
                n.cmd  = s.wr ? CMD_WR : CMD_RD;
                // (RQ1) (RQ2) select bit apart from column
                n.addr = {1'b0, s.bl8, 2'b00, s.col};
                n.beat = 4'h0;
                n.st   = S_DATA;
            end
            S_DATA:
            begin
                n.beat = s.beat + 4'h1;
                if (s.wr)
                begin
                    // (RQ16) strobe on every beat of the burst
                    n.dq   = s.wbuf[7:0];
                    n.wbuf = {8'h00, s.wbuf[63:8]};
                    n.dqs  = 1'b1;
                    n.oe   = 1'b1;
                    // (RQ1) data phase no shorter than command spacing
                    if (s.beat == len - 4'h1 && len >= CMD_SPACING)
                    begin
                        n.st = S_PRE;
                    end
                end
                else if (s.beat >= RD_CAPTURE)
                begin
                    n.rbuf = rb;
                    if (s.beat == len + RD_CAPTURE - 4'h1)
                    begin
                        // (RQ3) chop four returns low half only
                        n.rbuf     = s.bl8 ? rb : {32'h0000_0000, rb[63:32]};
                        n.rd_valid = 1'b1;
                        n.st       = S_PRE;
                    end
                end
            end
            S_PRE:
            begin
                // closing every bank keeps refresh always legal from idle
                n.cmd      = CMD_PRE;
                n.addr     = ADDR_PRE_ALL;
                n.dqs      = 1'b0;
                n.oe       = 1'b0;
                n.wait_cnt = RP_CYCLES - 8'h01;
                n.st       = S_WAIT;
            end
            S_WAIT:
            begin
                // (RQ8) nop only until cycle time has passed
                if (s.wait_cnt == 8'h00)
                begin
                    n.st        = S_IDLE;
                    n.init_done = 1'b1;
                end
                else
                begin
                    n.wait_cnt = s.wait_cnt - 8'h01;
                end
            end
            default:
            begin
                n.st = S_IDLE;
            end
        endcase
        // (RQ10) (RQ11) (RQ12) clamped debt, no credit past eight
        if (tick && !ref_issue && s.debt < DEBT_MAX)
        begin
            n.debt = s.debt + 5'sh01;
        end
        else if (!tick && ref_issue && s.debt > -DEBT_MAX)
        begin
            n.debt = s.debt - 5'sh01;
        end
        // (RQ10) no access taken once eight are owed
        n.req_ready = (n.st == S_IDLE) && (n.debt < DEBT_MAX);
        // (RQ13) self-refresh only with nothing owed
        n.sr_grant  = sr_req && (n.st == S_IDLE) && (n.debt <= 5'sh00);
    end

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= CTL_RST;
        end
        else
        begin
            s <= n;
        end
    end

    // ==========================================================
    // outputs
    assign link.cs_n      = s.cmd[3];
    assign link.ras_n     = s.cmd[2];
    assign link.cas_n     = s.cmd[1];
    assign link.we_n      = s.cmd[0];
    assign link.ba        = s.ba;
    assign link.addr      = s.addr;
    assign link.ctl_dq_o  = s.dq;
    assign link.ctl_dqs_o = s.dqs;
    assign link.ctl_oe    = s.oe;
    assign req_ready      = s.req_ready;
    assign rd_valid       = s.rd_valid;
    assign rd_data        = s.rbuf;
    assign sr_grant       = s.sr_grant;
    assign refresh_debt   = s.debt;
    assign init_done      = s.init_done;

endmodule

/* verilog/drbc_dram.sv */
// dram end: mode, bank, refresh and burst handling with a small array
`timescale 1ns/1ps
module drbc_dram
    import drbc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // link
    drbc_link_if.dram        link,
    // status
    output logic             refresh_active,
    output logic [13:0]      refresh_row,
    output logic [7:0]       banks_open,
    output logic [1:0]       burst_mode,
    output logic             wr_fault
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [1:0]      mode;
        logic [7:0]      open;
        logic [7:0][1:0] row_lo;
        logic [13:0]     ref_row;
        logic            ref_busy;
        logic [7:0]      ref_cnt;
        logic            act;
        logic            bwr;
        logic            bl8;
        logic [3:0]      beat;
        logic [2:0]      bba;
        logic [2:0]      bcol;
        logic [7:0]      dq_o;
        logic            dqs_o;
        logic            oe;
        logic            fault;
    } drbc_dev_t;

    drbc_dev_t  s;
    drbc_dev_t  n;
    logic [3:0] cmd;
    logic [7:0] mem_idx;
    logic       mem_we;
    logic [7:0] mem [0:255];

    assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};

    // ==========================================================
    // next state
    always_comb
    begin
        n         = s;
        n.fault   = 1'b0;
        mem_we    = 1'b0;
        mem_idx   = {s.bba, s.row_lo[s.bba], beat_col(s.bcol, s.beat, s.bl8)};
        if (s.ref_busy)
        begin
            n.ref_cnt = s.ref_cnt - 8'h01;
            if (s.ref_cnt == 8'h01)
            begin
                n.ref_busy = 1'b0;
                // (RQ7) banks left precharged
                n.open     = 8'h00;
            end
        end
        if (s.act)
        begin
            if (s.bwr)
            begin
                // (RQ14) damage stays local
                mem_we = 1'b1;
                // (RQ15) missing strobe flagged, burst still ends
                n.fault = ~link.dqs;
                n.beat  = s.beat + 4'h1;
                n.act   = (s.beat != beats(s.bl8) - 4'h1);
            end
            else if (s.beat == beats(s.bl8))
            begin
                n.oe  = 1'b0;
                n.dqs_o = 1'b0;
                n.act = 1'b0;
            end
            else
            begin
                n.dq_o  = mem[mem_idx];
                n.dqs_o = 1'b1;
                n.oe    = 1'b1;
                n.beat  = s.beat + 4'h1;
            end
        end
        // commands other than nop are ignored while refreshing
        if (!s.ref_busy)
        begin
            unique case (cmd)
                CMD_MRS:
                    if (link.ba == 3'h0)
                    begin
                        n.mode = link.addr[1:0];
                    end
                CMD_ACT:
                begin
                    n.open[link.ba]   = 1'b1;
                    n.row_lo[link.ba] = link.addr[1:0];
                end
                CMD_PRE:
                    if (link.addr[ADDR_AP_BIT])
                    begin
                        n.open = 8'h00;
                    end
                    else
                    begin
                        n.open[link.ba] = 1'b0;
                    end
                // (RQ4) refresh decode
                CMD_REF:
                begin
                    n.ref_busy = 1'b1;
                    n.ref_cnt  = RFC_CYCLES;
                    // (RQ6) internal row counter
                    n.ref_row  = s.ref_row + 14'h0001;
                end
                CMD_RD, CMD_WR:
                begin
                    n.act  = 1'b1;
                    n.bwr  = (cmd == CMD_WR);
                    // (RQ1) (RQ3) burst length select
                    n.bl8  = is_eight(s.mode, link.addr[ADDR_BL_BIT]);
                    n.bba  = link.ba;
                    // (RQ2) column excludes select bit
                    n.bcol = link.addr[2:0];
                    n.beat = 4'h0;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s         <= '0;
            s.mode    <= MODE_RST;
            s.ref_row <= REF_ROW_RST;
        end
        else
        begin
            s <= n;
        end
    end

    // array has no reset; contents are undefined until written
    always_ff @(posedge sys_clk)
    begin
        if (mem_we)
        begin
            mem[mem_idx] <= link.dq;
        end
    end

    assign link.dev_dq_o  = s.dq_o;
    assign link.dev_dqs_o = s.dqs_o;
    assign link.dev_oe    = s.oe;
    assign refresh_active = s.ref_busy;
    assign refresh_row    = s.ref_row;
    assign banks_open     = s.open;
    assign burst_mode     = s.mode;
    assign wr_fault       = s.fault;

endmodule

/* verilog/drbc_link_if.sv */
// command, address and data pins between memory controller and dram
`timescale 1ns/1ps
interface drbc_link_if;
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [2:0] ba;
    logic [13:0] addr;
    logic [7:0] ctl_dq_o;
    logic       ctl_dqs_o;
    logic       ctl_oe;
    logic [7:0] dev_dq_o;
    logic       dev_dqs_o;
    logic       dev_oe;
    logic [7:0] dq;
    logic       dqs;

    // wire levels resolved from the two enables; idle bus reads low
    assign dq  = ctl_oe ? ctl_dq_o : (dev_oe ? dev_dq_o : 8'h00);
    assign dqs = ctl_oe ? ctl_dqs_o : (dev_oe & dev_dqs_o);

    modport ctrl (
        output cs_n, ras_n, cas_n, we_n, ba, addr, ctl_dq_o, ctl_dqs_o, ctl_oe,
        input  dq, dqs
    );
    modport dram (
        input  cs_n, ras_n, cas_n, we_n, ba, addr, dq, dqs,
        output dev_dq_o, dev_dqs_o, dev_oe
    );
endinterface

/* verilog/drbc_pkg.sv */
// shared constants, command codes and helpers for the dram refresh/burst link
package drbc_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_PS = 50000;
    localparam int T_REFI_PS     = 7800000;
    localparam int T_RFC_PS      = 110000;
    localparam int T_RP_PS       = 13750;
    localparam int T_MRD_PS      = 200000;

    // average interval rounds down, least times round up
    localparam logic [7:0] REFI_CYCLES = 8'(T_REFI_PS / CLK_PERIOD_PS);
    localparam logic [7:0] RFC_CYCLES  = 8'((T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] RP_CYCLES   = 8'((T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] MRD_CYCLES  = 8'((T_MRD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // ==========================================================
    // burst and refresh figures
    localparam logic [3:0]        CMD_SPACING  = 4'h4;
    localparam logic [3:0]        BEATS_CHOP   = 4'h4;
    localparam logic [3:0]        BEATS_EIGHT  = 4'h8;
    localparam logic [3:0]        RD_CAPTURE   = 4'h2;
    localparam logic signed [4:0] DEBT_MAX     = 5'sh08;
    localparam logic [13:0]       REF_ROW_RST  = 14'h0000;

    // ==========================================================
    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_RD  = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_DES = 4'h8;

    // ==========================================================
    // address fields and mode register zero burst field
    localparam int          ADDR_BL_BIT  = 12;
    localparam int          ADDR_AP_BIT  = 10;
    localparam logic [13:0] ADDR_PRE_ALL = 14'h0400;
    localparam logic [1:0]  MODE_FIXED8  = 2'h0;
    localparam logic [1:0]  MODE_OTF     = 2'h1;
    localparam logic [1:0]  MODE_CHOP4   = 2'h2;
    localparam logic [1:0]  MODE_RST     = MODE_FIXED8;

    // ==========================================================
    // helpers
    function automatic logic is_eight(input logic [1:0] mode, input logic sel);
        is_eight = (mode == MODE_FIXED8) || ((mode == MODE_OTF) && sel);
    endfunction

    function automatic logic [3:0] beats(input logic eight);
        beats = eight ? BEATS_EIGHT : BEATS_CHOP;
    endfunction

    // sequential column order, wrapping inside the burst
    function automatic logic [2:0] beat_col(input logic [2:0] start,
                                            input logic [3:0] beat,
                                            input logic       eight);
        logic [2:0] sum;
        sum = start + beat[2:0];
        beat_col = eight ? sum : {start[2], sum[1:0]};
    endfunction

endpackage
